/* File: csm_pkg.sv */
// constants and types shared by both ends of the search memory
//
// Behaviour
// [RULE_01] memory holds 32 words of 32 bits
// [RULE_02] key compared against every word at once
// [RULE_03] match flag high when any word matches
// [RULE_04] don't-care bits never affect a match
// [RULE_05] encoded mode gives binary matching index
// [RULE_06] unencoded mode: 16 lines over two cycles
// [RULE_07] user keeps words unique for encoded mode
// [RULE_08] write takes two cycles, three with mask
// [RULE_09] preloaded contents, writable during operation
// [RULE_10] separate input and output side clocks
// [RULE_11] each of six paths optionally registered
// [RULE_12] local, global, chip reset clear everything
// [RULE_13] user drives enables, clock, clear; enable gates
// [RULE_14] four dedicated clocks plus global, local
// [RULE_15] first cycle words 0-15, second 16-31
// [RULE_16] encoded output five bits, zero on miss
// [RULE_17] lowest matching index wins in encoded mode
`default_nettype none
package csm_pkg;
	// ==================================================
	// array shape
	localparam int unsigned CSM_WORDS = 32;
	localparam int unsigned CSM_WIDTH = 32;
	localparam int unsigned CSM_AW    = 5;
	localparam int unsigned CSM_LINES = 16;
	localparam int unsigned CSM_NSRC  = 6;
	localparam logic [CSM_WORDS-1:0][CSM_WIDTH-1:0] CSM_INIT_WORDS = '0;
	// ==================================================
	// register path selects (bit index in path_reg)
	localparam int unsigned CSM_P_DIN   = 0;
	localparam int unsigned CSM_P_DOUT  = 1;
	localparam int unsigned CSM_P_RADDR = 2;
	localparam int unsigned CSM_P_WADDR = 3;
	localparam int unsigned CSM_P_WE    = 4;
	localparam int unsigned CSM_P_RE    = 5;
	// ==================================================
	// clock sources: 0..3 dedicated, then global, local
	localparam logic [2:0] CSM_SRC_GLOBAL = 3'h4;
	localparam logic [2:0] CSM_SRC_LOCAL  = 3'h5;
	// ==================================================
	// write sequencer states
	typedef enum logic [3:0] {
		CSM_W_IDLE = 4'h1,
		CSM_W_DATA = 4'h2,
		CSM_W_MASK = 4'h4,
		CSM_W_DONE = 4'h8
	} csm_wst_t;
	// ==================================================
	// controller register map (byte addresses)
	localparam logic [7:0] CSM_A_CTRL   = 8'h00;
	localparam logic [7:0] CSM_A_TICK   = 8'h04;
	localparam logic [7:0] CSM_A_WDATA  = 8'h08;
	localparam logic [7:0] CSM_A_WDC    = 8'h0C;
	localparam logic [7:0] CSM_A_WCMD   = 8'h10;
	localparam logic [7:0] CSM_A_KEY    = 8'h14;
	localparam logic [7:0] CSM_A_SRCH   = 8'h18;
	localparam logic [7:0] CSM_A_RESULT = 8'h1C;
	localparam logic [7:0] CSM_A_LINES  = 8'h20;
	localparam logic [7:0] CSM_A_STATUS = 8'h24;
	localparam logic [7:0] CSM_A_MASK   = 8'h28;
	localparam logic [7:0] CSM_A_CLR    = 8'h2C;
	// ctrl fields
	localparam int unsigned CSM_C_UNENC = 0;
	localparam int unsigned CSM_C_PATH  = 1;
	localparam int unsigned CSM_C_INSRC = 7;
	localparam int unsigned CSM_C_OUTSRC = 10;
	localparam int unsigned CSM_C_CEIN  = 13;
	localparam int unsigned CSM_C_CEOUT = 14;
	localparam logic [14:0] CSM_CTRL_RST = 15'h6000;
	localparam logic [5:0]  CSM_TICK_RST = 6'h3F;
	// wcmd fields
	localparam int unsigned CSM_WC_DCUSE = 5;
	localparam int unsigned CSM_WC_GO    = 8;
	// status / mask bits
	localparam int unsigned CSM_S_WDONE = 0;
	localparam int unsigned CSM_S_SDONE = 1;
	localparam int unsigned CSM_S_HIT   = 2;
	localparam int unsigned CSM_NSTAT   = 3;
	localparam logic [2:0]  CSM_MASK_RST = 3'h0;
	// result field
	localparam int unsigned CSM_R_MATCH = 8;
endpackage : csm_pkg
`default_nettype wire

/* File: csm_if.sv */
// link between the search memory and the user logic that drives it
`default_nettype none
interface csm_if;
	import csm_pkg::*;
	logic                 we;
	logic [CSM_AW-1:0]    wr_addr;
	logic [CSM_WIDTH-1:0] wr_data;
	logic [CSM_WIDTH-1:0] wr_dc;
	logic                 wr_dc_use;
	logic                 read_strobe;
	logic [CSM_WIDTH-1:0] key;
	logic                 unenc;
	logic [5:0]           path_reg;
	logic [2:0]           in_src;
	logic [2:0]           out_src;
	logic                 ce_in;
	logic                 ce_out;
	logic [CSM_NSRC-1:0]  src_tick;
	logic                 clr_local;
	logic                 clr_global;
	logic                 wr_done;
	logic                 res_valid;
	logic                 res_match;
	logic [CSM_AW-1:0]    res_addr;
	logic [CSM_LINES-1:0] res_lines;
	logic                 res_hi;
	modport dev (
		input  we, wr_addr, wr_data, wr_dc, wr_dc_use, read_strobe, key, unenc,
		input  path_reg, in_src, out_src, ce_in, ce_out, src_tick,
		input  clr_local, clr_global,
		output wr_done, res_valid, res_match, res_addr, res_lines, res_hi
	);
	modport usr (
		output we, wr_addr, wr_data, wr_dc, wr_dc_use, read_strobe, key, unenc,
		output path_reg, in_src, out_src, ce_in, ce_out, src_tick,
		output clr_local, clr_global,
		input  wr_done, res_valid, res_match, res_addr, res_lines, res_hi
	);
endinterface : csm_if
`default_nettype wire

/* File: csm_match_row.sv */
// one stored word compared against the key, masked bits ignored
`default_nettype none
module csm_match_row
	import csm_pkg::*;
(
	input  wire logic [CSM_WIDTH-1:0] key,
	input  wire logic [CSM_WIDTH-1:0] word,
	input  wire logic [CSM_WIDTH-1:0] dont_care,
	output logic                      hit
);
	// ==================================================
	// a masked bit counts as equal whatever the key holds
	assign hit = &((key ~^ word) | dont_care); // [RULE_04]
endmodule : csm_match_row
`default_nettype wire

/* File: csm_device.sv */
// search memory end: storage, parallel compare, result encoding
//
// The implementer's own choices: register access over APB and the register addresses.
`default_nettype none
module csm_device
	import csm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic arst_n,
	csm_if.dev        lnk
);
	import csm_pkg::*;

	typedef struct packed {
		logic [CSM_WORDS-1:0][CSM_WIDTH-1:0] data;
		logic [CSM_WORDS-1:0][CSM_WIDTH-1:0] dc;
		csm_wst_t             wst;
		logic                 we_q;
		logic                 dcuse_q;
		logic [CSM_AW-1:0]    waddr_q;
		logic [CSM_WIDTH-1:0] wdata_q;
		logic [CSM_WIDTH-1:0] wdc_q;
		logic                 re_q;
		logic [CSM_WIDTH-1:0] key_q;
		logic [CSM_WORDS-1:0] pipe_vec;
		logic                 pipe_v;
		logic [CSM_LINES-1:0] hold_hi;
		logic                 hi_pend;
		logic                 wr_done;
		logic                 valid;
		logic                 match;
		logic [CSM_AW-1:0]    enc;
		logic [CSM_LINES-1:0] lines;
		logic                 hi_phase;
	} csm_dev_state_t;

	csm_dev_state_t st_reg;
	csm_dev_state_t st_next;

	logic                 clr_n;
	logic                 in_go;
	logic                 out_go;
	logic                 we_s;
	logic                 dcuse_s;
	logic                 re_s;
	logic [CSM_AW-1:0]    waddr_s;
	logic [CSM_WIDTH-1:0] wdata_s;
	logic [CSM_WIDTH-1:0] wdc_s;
	logic [CSM_WIDTH-1:0] key_s;
	logic [CSM_WORDS-1:0] hit_vec;
	logic [CSM_WORDS-1:0] launch_vec;
	logic                 launch_v;

	// ==================================================
	// clearing
	// any of the three clears empties every register; the two
	// user clears come from flops so the combined reset is clean
	assign clr_n = arst_n & ~lnk.clr_local & ~lnk.clr_global; // [RULE_12]

	// ==================================================
	// clock source selection
	// both sides run on clk_sys; the chosen source acts as the
	// edge qualifier of that side, gated by the side's enable
	function automatic logic pick_src(input logic [2:0] sel,
	                                  input logic [CSM_NSRC-1:0] tick);
		logic r;
		r = 1'b0;
		if (sel < 3'(CSM_NSRC)) begin
			r = tick[sel];
		end
		return r;
	endfunction : pick_src

	assign in_go  = pick_src(lnk.in_src, lnk.src_tick) & lnk.ce_in;    // [RULE_10] [RULE_13] [RULE_14]
	assign out_go = pick_src(lnk.out_src, lnk.src_tick) & lnk.ce_out;  // [RULE_10] [RULE_13] [RULE_14]

	// ==================================================
	// path register bypass: each path uses its stage or the pin
	assign wdata_s = lnk.path_reg[CSM_P_DIN]   ? st_reg.wdata_q : lnk.wr_data;   // [RULE_11]
	assign wdc_s   = lnk.path_reg[CSM_P_DIN]   ? st_reg.wdc_q   : lnk.wr_dc;     // [RULE_11]
	assign waddr_s = lnk.path_reg[CSM_P_WADDR] ? st_reg.waddr_q : lnk.wr_addr;   // [RULE_11]
	assign we_s    = lnk.path_reg[CSM_P_WE]    ? st_reg.we_q    : lnk.we;        // [RULE_11]
	assign dcuse_s = lnk.path_reg[CSM_P_WE]    ? st_reg.dcuse_q : lnk.wr_dc_use; // [RULE_11]
	assign key_s   = lnk.path_reg[CSM_P_RADDR] ? st_reg.key_q   : lnk.key;       // [RULE_11]
	assign re_s    = lnk.path_reg[CSM_P_RE]    ? st_reg.re_q    : lnk.read_strobe; // [RULE_11]

	// ==================================================
	// compare the key against all words in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < CSM_WORDS; gi++) begin : g_row
			csm_match_row u_row (
				.key       (key_s),
				.word      (st_reg.data[gi]),
				.dont_care (st_reg.dc[gi]),
				.hit       (hit_vec[gi])
			); // [RULE_01] [RULE_02]
		end
	endgenerate

	// optional output stage sits between compare and result flops
	assign launch_vec = lnk.path_reg[CSM_P_DOUT] ? st_reg.pipe_vec : hit_vec; // [RULE_11]
	assign launch_v   = lnk.path_reg[CSM_P_DOUT] ? st_reg.pipe_v   : re_s;    // [RULE_11]

	// lowest set index; duplicates in encoded mode are the user's
	// problem, this only keeps the answer repeatable
	function automatic logic [CSM_AW-1:0] lowest(input logic [CSM_WORDS-1:0] v);
		logic [CSM_AW-1:0] r;
		r = '0;
		for (int i = CSM_WORDS - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = CSM_AW'(i); // [RULE_17] [RULE_07]
			end
		end
		return r;
	endfunction : lowest

	// ==================================================
	// next state
	always_comb begin
		st_next = st_reg;
		// input side: path stages and the write sequencer
		if (in_go) begin
			st_next.we_q    = lnk.we;
			st_next.dcuse_q = lnk.wr_dc_use;
			st_next.waddr_q = lnk.wr_addr;
			st_next.wdata_q = lnk.wr_data;
			st_next.wdc_q   = lnk.wr_dc;
			st_next.re_q    = lnk.read_strobe;
			st_next.key_q   = lnk.key;
			unique case (st_reg.wst)
				CSM_W_IDLE: begin
					if (we_s) begin
						st_next.wst = CSM_W_DATA; // [RULE_08] cycle one
					end
				end
				CSM_W_DATA: begin
					st_next.data[waddr_s] = wdata_s; // [RULE_09]
					st_next.dc[waddr_s]   = '0;
					if (dcuse_s) begin
						st_next.wst = CSM_W_MASK; // [RULE_08] third cycle
					end else begin
						st_next.wst     = CSM_W_DONE;
						st_next.wr_done = 1'b1;
					end
				end
				CSM_W_MASK: begin
					st_next.dc[waddr_s] = wdc_s; // [RULE_04]
					st_next.wst         = CSM_W_DONE;
					st_next.wr_done     = 1'b1;
				end
				CSM_W_DONE: begin
					// wait for the writer to let go, so a held enable
					// never starts a second write of the same word
					if (!we_s) begin
						st_next.wst     = CSM_W_IDLE;
						st_next.wr_done = 1'b0;
					end
				end
				default: begin
					st_next.wst = CSM_W_IDLE;
				end
			endcase
		end
		// output side: result stage and two-cycle line readout
		if (out_go) begin
			st_next.pipe_vec = hit_vec;
			st_next.pipe_v   = re_s;
			st_next.valid    = 1'b0;
			st_next.hi_phase = 1'b0;
			if (st_reg.hi_pend) begin
				// second cycle; a search offered now is not taken
				st_next.lines    = st_reg.hold_hi; // [RULE_06] [RULE_15]
				st_next.hi_phase = 1'b1;
				st_next.valid    = 1'b1;
				st_next.hi_pend  = 1'b0;
			end else if (launch_v) begin
				st_next.valid = 1'b1;
				st_next.match = |launch_vec;        // [RULE_03]
				st_next.enc   = lowest(launch_vec); // [RULE_05] [RULE_16]
				if (lnk.unenc) begin
					st_next.lines   = launch_vec[CSM_LINES-1:0];         // [RULE_06] [RULE_15]
					st_next.hold_hi = launch_vec[CSM_WORDS-1:CSM_LINES]; // [RULE_15]
					st_next.hi_pend = 1'b1;
				end else begin
					st_next.lines = '0;
				end
			end
		end
	end

	// ==================================================
	// state register; preloaded words come back on every clear
	always_ff @(posedge clk_sys or negedge clr_n) begin
		if (!clr_n) begin
			st_reg          <= '0;
			st_reg.data     <= CSM_INIT_WORDS; // [RULE_09]
			st_reg.wst      <= CSM_W_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==================================================
	// outputs straight from the state flops
	assign lnk.wr_done   = st_reg.wr_done;
	assign lnk.res_valid = st_reg.valid;
	assign lnk.res_match = st_reg.match;
	assign lnk.res_addr  = st_reg.enc;
	assign lnk.res_lines = st_reg.lines;
	assign lnk.res_hi    = st_reg.hi_phase;
endmodule : csm_device
`default_nettype wire

/* File: csm_host.sv */
// user-logic end: apb registers that drive writes and searches
`default_nettype none
module csm_host
	import csm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	csm_if.usr               lnk
);
	import csm_pkg::*;

	typedef struct packed {
		logic [14:0]          ctrl;
		logic [CSM_NSRC-1:0]  tick;
		logic [CSM_WIDTH-1:0] wdata;
		logic [CSM_WIDTH-1:0] wdc;
		logic [CSM_AW-1:0]    waddr;
		logic                 dcuse;
		logic                 we;
		logic                 re;
		logic [CSM_WIDTH-1:0] key;
		logic [CSM_AW-1:0]    raddr;
		logic                 rmatch;
		logic [31:0]          lines;
		logic [CSM_NSTAT-1:0] status;
		logic [CSM_NSTAT-1:0] mask;
		logic                 clr_l;
		logic                 clr_g;
		logic                 irq;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
	} csm_host_state_t;

	csm_host_state_t st_reg;
	csm_host_state_t st_next;
	logic [CSM_NSTAT-1:0] ev;
	logic                 setup;
	logic                 done;
	logic [7:0]           a;

	assign a     = paddr[7:0];
	assign setup = psel & ~penable;
	assign done  = psel & penable & st_reg.pready;

	// ==================================================
	// device events
	always_comb begin
		ev = '0;
		ev[CSM_S_WDONE] = lnk.wr_done & st_reg.we;
		ev[CSM_S_SDONE] = lnk.res_valid & (lnk.res_hi | ~st_reg.ctrl[CSM_C_UNENC]);
		ev[CSM_S_HIT]   = ev[CSM_S_SDONE] & lnk.res_match;
	end

	// ==================================================
	// next state
	always_comb begin
		st_next        = st_reg;
		st_next.re     = 1'b0;
		st_next.clr_l  = 1'b0;
		st_next.clr_g  = 1'b0;
		st_next.pready = 1'b0;
		// write strobe held until the device reports the store
		if (ev[CSM_S_WDONE]) begin
			st_next.we = 1'b0; // [RULE_08]
		end
		// both line halves are captured; the reader needs both
		if (lnk.res_valid) begin
			if (lnk.res_hi) begin
				st_next.lines[31:16] = lnk.res_lines; // [RULE_06]
			end else begin
				st_next.lines  = {16'h0000, lnk.res_lines};
				st_next.raddr  = lnk.res_addr;
				st_next.rmatch = lnk.res_match;
			end
		end
		// answer decided in the setup cycle, shown in the access
		if (setup) begin
			st_next.pready  = 1'b1;
			st_next.pslverr = 1'b0;
			st_next.prdata  = 32'h0000_0000;
			unique case (a)
				CSM_A_CTRL:   st_next.prdata = {17'h00000, st_reg.ctrl};
				CSM_A_TICK:   st_next.prdata = {26'h0000000, st_reg.tick};
				CSM_A_WDATA:  st_next.prdata = st_reg.wdata;
				CSM_A_WDC:    st_next.prdata = st_reg.wdc;
				CSM_A_WCMD:   st_next.prdata = {23'h000000, st_reg.we, 2'h0,
				                                 st_reg.dcuse, st_reg.waddr};
				CSM_A_KEY:    st_next.prdata = st_reg.key;
				CSM_A_SRCH:   st_next.prdata = 32'h0000_0000;
				CSM_A_RESULT: st_next.prdata = {23'h000000, st_reg.rmatch, 3'h0, st_reg.raddr};
				CSM_A_LINES:  st_next.prdata = st_reg.lines;
				CSM_A_STATUS: st_next.prdata = {29'h00000000, st_reg.status};
				CSM_A_MASK:   st_next.prdata = {29'h00000000, st_reg.mask};
				CSM_A_CLR:    st_next.prdata = 32'h0000_0000;
				default:      st_next.pslverr = 1'b1;
			endcase
		end
		// writes and read side effects take place at completion
		if (done && pwrite) begin
			unique case (a)
				CSM_A_CTRL:  st_next.ctrl  = pwdata[14:0];
				CSM_A_TICK:  st_next.tick  = pwdata[CSM_NSRC-1:0]; // [RULE_14]
				CSM_A_WDATA: st_next.wdata = pwdata;
				CSM_A_WDC:   st_next.wdc   = pwdata;
				CSM_A_WCMD: begin
					if (pwdata[CSM_WC_GO] && !st_reg.we) begin
						st_next.waddr = pwdata[CSM_AW-1:0];
						st_next.dcuse = pwdata[CSM_WC_DCUSE];
						st_next.we    = 1'b1; // [RULE_13]
					end
				end
				CSM_A_KEY:   st_next.key   = pwdata;
				CSM_A_SRCH:  st_next.re    = 1'b1; // [RULE_13]
				CSM_A_MASK:  st_next.mask  = pwdata[CSM_NSTAT-1:0];
				CSM_A_CLR: begin
					st_next.clr_l = pwdata[0]; // [RULE_12]
					st_next.clr_g = pwdata[1]; // [RULE_12]
				end
				default: begin
				end
			endcase
		end
		// read of status clears it; a new event in that cycle stays
		if (done && !pwrite && a == CSM_A_STATUS) begin
			st_next.status = '0;
		end
		st_next.status = st_next.status | ev;
		st_next.irq    = |(st_next.status & st_next.mask);
	end

	// ==================================================
	// state register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg      <= '0;
			st_reg.ctrl <= CSM_CTRL_RST;
			st_reg.tick <= CSM_TICK_RST;
			st_reg.mask <= CSM_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==================================================
	// outputs from flops
	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign irq     = st_reg.irq;
	assign lnk.we          = st_reg.we;
	assign lnk.wr_addr     = st_reg.waddr;
	assign lnk.wr_data     = st_reg.wdata;
	assign lnk.wr_dc       = st_reg.wdc;
	assign lnk.wr_dc_use   = st_reg.dcuse;
	assign lnk.read_strobe = st_reg.re;
	assign lnk.key         = st_reg.key;
	assign lnk.unenc       = st_reg.ctrl[CSM_C_UNENC];
	assign lnk.path_reg    = st_reg.ctrl[CSM_C_PATH +: 6];
	assign lnk.in_src      = st_reg.ctrl[CSM_C_INSRC +: 3];
	assign lnk.out_src     = st_reg.ctrl[CSM_C_OUTSRC +: 3];
	assign lnk.ce_in       = st_reg.ctrl[CSM_C_CEIN];
	assign lnk.ce_out      = st_reg.ctrl[CSM_C_CEOUT];
	assign lnk.src_tick    = st_reg.tick;
	assign lnk.clr_local   = st_reg.clr_l;
	assign lnk.clr_global  = st_reg.clr_g;
endmodule : csm_host
`default_nettype wire

/* File: csm_checker.sv */
// concurrent checks on the link between the two ends of the search memory
`default_nettype none
module csm_checker
	import csm_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 arst_n,
	input wire logic                 we,
	input wire logic [CSM_WIDTH-1:0] wr_data,
	input wire logic                 wr_dc_use,
	input wire logic                 read_strobe,
	input wire logic                 unenc,
	input wire logic [5:0]           path_reg,
	input wire logic                 clr_local,
	input wire logic                 clr_global,
	input wire logic                 wr_done,
	input wire logic                 res_valid,
	input wire logic                 res_match,
	input wire logic [CSM_AW-1:0]    res_addr,
	input wire logic [CSM_LINES-1:0] res_lines,
	input wire logic                 res_hi
);
	timeunit 1ns;
	timeprecision 1ns;
	// single domain, so one clock and one disable for all
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// ==================================================
	// write handshake, only timed with every path unregistered
	AST_WRITE_TWO: assert property (
		$rose(we) && !wr_dc_use && path_reg == 6'h00 |-> !wr_done [*2] ##1 wr_done
	) else $error("plain write not stored after two cycles");
	AST_WRITE_MASK: assert property (
		$rose(we) && wr_dc_use && path_reg == 6'h00 |-> !wr_done [*3] ##1 wr_done
	) else $error("masked write not stored after three cycles");
	AST_WDONE_DROP: assert property (
		$fell(we) && path_reg == 6'h00 |=> !wr_done
	) else $error("write done not released after request dropped");
	AST_WE_HOLD: assert property (
		we && !wr_done |=> we && $stable(wr_data)
	) else $error("write request not held until done");
	// ==================================================
	// search results
	AST_SEARCH_LAT: assert property (
		read_strobe && !unenc && path_reg == 6'h00 |=> res_valid
	) else $error("encoded result not one cycle after strobe");
	AST_UNENC_PAIR: assert property (
		res_valid && unenc && !res_hi && path_reg == 6'h00 |=> res_valid && res_hi
	) else $error("second unencoded cycle missing");
	AST_HI_UNENC: assert property (
		res_valid && res_hi |-> unenc
	) else $error("upper half flagged in encoded mode");
	AST_ENC_MISS: assert property (
		res_valid && !unenc && !res_match |-> res_addr == '0 && res_lines == '0
	) else $error("encoded miss not reported as zero");
	AST_CLR: assert property (
		clr_local || clr_global |-> !res_valid && !wr_done && res_lines == '0
	) else $error("clear pulse left device outputs set");
	// ==================================================
	// main scenarios reached
	COV_UNENC: cover property (res_valid && res_hi);
	COV_MASKW: cover property ($rose(we) && wr_dc_use);
	COV_HIT:   cover property (res_valid && !unenc && res_match);
endmodule : csm_checker
`default_nettype wire

/* File: content_addressable_search_memory_bench.sv */
// self-checking bench: apb host end joined to the search memory end
`default_nettype none
module content_addressable_search_memory_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import csm_pkg::*;
	typedef struct packed {
		logic [31:0] key;
		logic        unenc;
		logic [31:0] res;
		logic [31:0] lines;
	} csm_row_t;
	logic        clk_sys;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] rd;
	logic        perr;
	int          bad_count;
	int          n_tests;
	// words 2 and 20 equal, 12 masked low half, 31 all ones, rest zero
	localparam csm_row_t ROWS [10] = '{
		'{32'h1234_5678, 1'b0, 32'h0000_0102, 32'h0000_0000},
		'{32'h1234_5678, 1'b1, 32'h0000_0000, 32'h0010_0004},
		'{32'hCAFE_1234, 1'b0, 32'h0000_010C, 32'h0000_0000},
		'{32'hCAFE_1234, 1'b1, 32'h0000_0000, 32'h0000_1000},
		'{32'hFFFF_FFFF, 1'b0, 32'h0000_011F, 32'h0000_0000},
		'{32'hFFFF_FFFF, 1'b1, 32'h0000_0000, 32'h8000_0000},
		'{32'h0000_0000, 1'b0, 32'h0000_0100, 32'h0000_0000},
		'{32'h0000_0000, 1'b1, 32'h0000_0000, 32'h7FEF_EFFB},
		'{32'hDEAD_BEEF, 1'b1, 32'h0000_0000, 32'h0000_0000},
		'{32'hDEAD_BEEF, 1'b0, 32'h0000_0000, 32'h0000_0000}
	};
	csm_if u_csm_if ();
	csm_device u_csm_device (.clk_sys(clk_sys), .arst_n(arst_n), .lnk(u_csm_if.dev));
	csm_host u_csm_host (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .lnk(u_csm_if.usr)
	);
	csm_checker u_csm_checker (
		.clk_sys(clk_sys), .arst_n(arst_n), .we(u_csm_if.we), .wr_data(u_csm_if.wr_data),
		.wr_dc_use(u_csm_if.wr_dc_use), .read_strobe(u_csm_if.read_strobe),
		.unenc(u_csm_if.unenc), .path_reg(u_csm_if.path_reg),
		.clr_local(u_csm_if.clr_local), .clr_global(u_csm_if.clr_global),
		.wr_done(u_csm_if.wr_done), .res_valid(u_csm_if.res_valid),
		.res_match(u_csm_if.res_match), .res_addr(u_csm_if.res_addr),
		.res_lines(u_csm_if.res_lines), .res_hi(u_csm_if.res_hi)
	);
	// ==================================================
	// clock and report
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic fail(input string m);
		bad_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail($sformatf("got %h expected %h", got, exp));
		end
	endtask : chk
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	// ==================================================
	// apb master: answer taken at the rising edge that sees pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			fail("no bus answer");
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic search(input logic [31:0] key);
		apb(1'b1, CSM_A_KEY, key);
		apb(1'b1, CSM_A_SRCH, 32'h0000_0000);
		// result lands a few edges later when paths are registered
		repeat (4) @(posedge clk_sys);
	endtask : search
	// write start, then poll busy; a hang here is cut short, not waited out
	task automatic wr_word(input logic [4:0] a, input logic [31:0] d, input logic [31:0] dc,
			input logic use_dc);
		int k;
		apb(1'b1, CSM_A_WDATA, d);
		apb(1'b1, CSM_A_WDC, dc);
		apb(1'b1, CSM_A_WCMD, {23'h000000, 1'b1, 2'h0, use_dc, a});
		k = 0;
		do begin
			apb(1'b0, CSM_A_WCMD, 32'h0000_0000);
			k++;
		end while (rd[8] !== 1'b0 && k < 20);
		if (k >= 20) begin
			fail("write never finished");
		end
	endtask : wr_word
	task automatic chk_irq(input logic exp);
		@(negedge clk_sys);
		chk({31'h0, irq}, {31'h0, exp});
		@(posedge clk_sys);
	endtask : chk_irq
	// ==================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		bad_count = 0;
		n_tests = 0;
		arst_n = 1'b0;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		wr_word(5'h02, 32'h1234_5678, 32'h0000_0000, 1'b0);
		wr_word(5'h0C, 32'hCAFE_0000, 32'h0000_FFFF, 1'b1);
		wr_word(5'h14, 32'h1234_5678, 32'h0000_0000, 1'b0);
		wr_word(5'h1F, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		foreach (ROWS[i]) begin
			apb(1'b1, CSM_A_CTRL, {17'h00000, CSM_CTRL_RST} | {31'h0, ROWS[i].unenc});
			search(ROWS[i].key);
			apb(1'b0, CSM_A_LINES, 32'h0000_0000);
			chk(rd, ROWS[i].lines);
			if (!ROWS[i].unenc) begin
				apb(1'b0, CSM_A_RESULT, 32'h0000_0000);
				chk(rd, ROWS[i].res);
			end
		end
		// interrupt: masked event stays quiet, unmasked one raises the line
		apb(1'b0, CSM_A_STATUS, 32'h0000_0000);
		search(32'hDEAD_BEEF);
		chk_irq(1'b0);
		apb(1'b0, CSM_A_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		apb(1'b0, CSM_A_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, CSM_A_MASK, 32'h0000_0004);
		search(32'hFFFF_FFFF);
		chk_irq(1'b1);
		apb(1'b0, CSM_A_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0006);
		chk_irq(1'b0);
		// unmapped place refused
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk({31'h0, perr}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		// local then global clear wipes a fresh word
		apb(1'b1, CSM_A_CTRL, 32'h0000_6000);
		for (int c = 1; c <= 2; c++) begin
			wr_word(5'h05, 32'hAAAA_AAAA, 32'h0000_0000, 1'b0);
			apb(1'b1, CSM_A_CLR, 32'(c));
			search(32'hAAAA_AAAA);
			apb(1'b0, CSM_A_RESULT, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
		end
		// all paths registered, global in clock, local out clock
		apb(1'b1, CSM_A_CTRL, 32'h0000_767E);
		wr_word(5'h07, 32'h0000_7777, 32'h0000_0000, 1'b0);
		search(32'h0000_7777);
		apb(1'b0, CSM_A_RESULT, 32'h0000_0000);
		chk(rd, 32'h0000_0107);
		// second reset mid-run: registers and memory back to defaults
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		apb(1'b0, CSM_A_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_6000);
		apb(1'b0, CSM_A_TICK, 32'h0000_0000);
		chk(rd, 32'h0000_003F);
		apb(1'b0, CSM_A_MASK, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		search(32'h0000_7777);
		apb(1'b0, CSM_A_RESULT, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		// output enable low: no result; high again: word 0 reported
		for (int e = 0; e < 2; e++) begin
			apb(1'b1, CSM_A_CTRL, e ? 32'h0000_6000 : 32'h0000_2001);
			search(32'h0000_0000);
			apb(1'b0, CSM_A_RESULT, 32'h0000_0000);
			chk(rd, e ? 32'h0000_0100 : 32'h0000_0000);
		end
		conclude();
	end
	// hang guard, well beyond the several hundred cycles the tests need
	initial begin
		#6000000;
		fail("timeout");
		conclude();
	end
endmodule : content_addressable_search_memory_bench
`default_nettype wire
